// *** common/sgp_if.sv ***
// Link between the prefetch manager and the host memory / acquisition engine side.
`timescale 1ns/100ps
interface sgp_if;
  import sgp_pkg::*;
  logic rd_req_valid;
  logic [ADDR_W-1:0] rd_req_addr;
  logic [3:0] rd_req_log;
  logic rd_req_ready;
  logic cpl_valid;
  logic [DESC_W-1:0] cpl_data;
  logic desc_valid;
  logic [DESC_W-1:0] desc_data;
  logic desc_ready;

  modport mgr (
    output rd_req_valid, rd_req_addr, rd_req_log, desc_valid, desc_data,
    input rd_req_ready, cpl_valid, cpl_data, desc_ready
  );
  modport far (
    input rd_req_valid, rd_req_addr, rd_req_log, desc_valid, desc_data,
    output rd_req_ready, cpl_valid, cpl_data, desc_ready
  );
endinterface : sgp_if

// *** common/sgp_pkg.sv ***
// Shared constants, register map and state types of the descriptor prefetcher.
package sgp_pkg;
  // Descriptor and host address geometry.
  localparam int ADDR_W = 64;
  localparam int DESC_W = 64;
  localparam logic [7:0] DESC_BYTES = 8'h08;
  localparam logic [3:0] DESC_BYTES_LOG = 4'h3;
  localparam logic [3:0] MRRS_BASE_LOG = 4'h7;
  localparam logic [3:0] GROUP_LOG_MAX = 4'hf;
  // Register indices on the register port.
  localparam int REG_IDX_W = 2;
  localparam logic [1:0] REG_ADDR_LO = 2'h0;
  localparam logic [1:0] REG_ADDR_HI = 2'h1;
  localparam logic [1:0] REG_CTRL = 2'h2;
  localparam logic [1:0] REG_TMO = 2'h3;
  // Field positions.
  localparam int RUN_LSB = 0;
  localparam int STATE_LSB = 4;
  localparam int ERR_BIT = 8;
  localparam int CUR_LSB = 24;
  localparam int MAX_LSB = 28;
  localparam int TMO_LSB = 0;
  localparam int TMO_DIS_BIT = 31;
  // Run level commands.
  localparam logic [3:0] RUN_IDLE = 4'h0;
  localparam logic [3:0] RUN_GO = 4'h1;
  localparam logic [3:0] RUN_ABORT = 4'h2;
  // Reset values.
  localparam logic [31:0] ADDR_RST = 32'h0000_0000;
  localparam logic [15:0] TMO_RST = 16'hffff;
  localparam logic TMO_DIS_RST = 1'b0;
  // Timing: clock period and timeout unit, both in ns.
  localparam logic [18:0] CLK_NS = 19'h00019;
  localparam logic [2:0] TMO_UNIT_NS = 3'h4;

  typedef enum logic [1:0] {ST_IDLE, ST_REQ, ST_WAIT, ST_DRAIN} sgp_state_e;
  typedef enum logic [1:0] {ENG_STOPPED, ENG_RUNNING, ENG_STOPPING} sgp_eng_e;
endpackage : sgp_pkg

// *** design/sgp_cache.sv ***
// Local descriptor cache: a flushable FIFO with registered valid.
`timescale 1ns/100ps
module sgp_cache
  import sgp_pkg::*;
#(
  parameter int DEPTH_LOG = 4
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic flush,
  input wire logic wr_valid,
  input wire logic [DESC_W-1:0] wr_data,
  output logic [DEPTH_LOG:0] free,
  output logic rd_valid,
  output logic [DESC_W-1:0] rd_data,
  input wire logic rd_ready
);
  localparam logic [DEPTH_LOG:0] DEPTH = (DEPTH_LOG+1)'(1 << DEPTH_LOG);

  typedef struct packed {
    logic [DEPTH_LOG-1:0] wp;
    logic [DEPTH_LOG-1:0] rp;
    logic [DEPTH_LOG:0] cnt;
    logic valid;
  } sgp_cache_s;

  sgp_cache_s s_r, s_nxt;
  logic [DESC_W-1:0] mem [0:(1<<DEPTH_LOG)-1];
  logic push;
  logic pop;

  // A write into a full cache is dropped; the manager reserves room before asking.
  assign push = wr_valid && (s_r.cnt != DEPTH) && !flush;
  assign pop = s_r.valid && rd_ready && !flush;

  // Pointer and occupancy update; flush discards every held entry.
  always_comb begin
    s_nxt = s_r;
    if (flush) begin
      s_nxt.wp = '0;
      s_nxt.rp = '0;
      s_nxt.cnt = '0;
    end else begin
      if (push) begin
        s_nxt.wp = s_r.wp + 1'b1;
      end
      if (pop) begin
        s_nxt.rp = s_r.rp + 1'b1;
      end
      s_nxt.cnt = s_r.cnt + (DEPTH_LOG+1)'(push) - (DEPTH_LOG+1)'(pop);
    end
    s_nxt.valid = (s_nxt.cnt != '0);
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Storage has no reset; only entries counted as held are ever read.
  always_ff @(posedge clock) begin
    if (push) begin
      mem[s_r.wp] <= wr_data;
    end
  end

  assign free = DEPTH - s_r.cnt;
  assign rd_valid = s_r.valid;
  assign rd_data = mem[s_r.rp];
endmodule : sgp_cache

// *** design/sgp_far.sv ***
// Far end: host memory read responder and acquisition engine descriptor consumer.
`timescale 1ns/100ps
module sgp_far
  import sgp_pkg::*;
(
  input wire logic clock,
  input wire logic resetn,
  sgp_if.far link,
  output logic mem_rd_en,
  output logic [ADDR_W-1:0] mem_addr,
  input wire logic [DESC_W-1:0] mem_rdata,
  input wire logic eng_start,
  input wire logic eng_stop,
  input wire logic eng_abort,
  input wire logic chunk_done,
  output logic [1:0] eng_state,
  output logic cur_valid,
  output logic [DESC_W-1:0] cur_desc
);
  typedef struct packed {
    logic busy;
    logic [ADDR_W-1:0] addr;
    logic [15:0] remain;
    logic rd_en;
    logic [ADDR_W-1:0] rd_addr;
    logic cpl_valid;
    logic [DESC_W-1:0] cpl_data;
    logic req_ready;
    sgp_eng_e eng;
    logic have;
    logic [DESC_W-1:0] desc;
    logic desc_ready;
  } sgp_far_s;

  sgp_far_s s_r, s_nxt;

  // One memory word per cycle streams back as one completion beat per descriptor.
  always_comb begin
    s_nxt = s_r;
    s_nxt.rd_en = 1'b0;
    s_nxt.cpl_valid = s_r.rd_en;
    s_nxt.cpl_data = mem_rdata;
    if (!s_r.busy && s_r.req_ready && link.rd_req_valid) begin
      s_nxt.busy = 1'b1;
      s_nxt.addr = link.rd_req_addr;
      s_nxt.remain = 16'h0001 << link.rd_req_log;
    end else if (s_r.busy) begin
      s_nxt.rd_en = 1'b1;
      s_nxt.rd_addr = s_r.addr;
      s_nxt.addr = s_r.addr + ADDR_W'(DESC_BYTES);
      s_nxt.remain = s_r.remain - 16'h0001;
      s_nxt.busy = (s_r.remain != 16'h0001);
    end
    s_nxt.req_ready = !s_nxt.busy;
    // Engine commands are honoured whatever the manager is doing.
    if (chunk_done && s_r.have) begin
      s_nxt.have = 1'b0;
      if (s_r.eng == ENG_STOPPING) begin
        s_nxt.eng = ENG_STOPPED;
      end
    end
    if (link.desc_valid && s_r.desc_ready) begin
      s_nxt.have = 1'b1;
      s_nxt.desc = link.desc_data;
    end
    if (eng_abort) begin
      s_nxt.eng = ENG_STOPPED;
      s_nxt.have = 1'b0;
    end else if (eng_stop) begin
      s_nxt.eng = s_nxt.have ? ENG_STOPPING : ENG_STOPPED;
    end else if (eng_start) begin
      s_nxt.eng = ENG_RUNNING;
    end
    // Without a descriptor a running engine simply waits for the next one.
    s_nxt.desc_ready = (s_nxt.eng == ENG_RUNNING) && !s_nxt.have;
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      s_r <= '{eng: ENG_STOPPED, default: '0};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign link.rd_req_ready = s_r.req_ready;
  assign link.cpl_valid = s_r.cpl_valid;
  assign link.cpl_data = s_r.cpl_data;
  assign link.desc_ready = s_r.desc_ready;
  assign mem_rd_en = s_r.rd_en;
  assign mem_addr = s_r.rd_addr;
  assign eng_state = s_r.eng;
  assign cur_valid = s_r.have;
  assign cur_desc = s_r.desc;
endmodule : sgp_far

// *** design/sgp_mgr.sv ***
// Descriptor prefetch manager: registers, fetch sequencer and cache.
`timescale 1ns/100ps
module sgp_mgr
  import sgp_pkg::*;
#(
  parameter int CACHE_LOG = 4
) (
  input wire logic clock,
  input wire logic resetn,
  sgp_if.mgr link,
  input wire logic [2:0] max_read_req,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [REG_IDX_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  output logic [31:0] reg_rdata
);
  localparam logic [3:0] CACHE_LOG_V = 4'(CACHE_LOG);

  typedef struct packed {
    sgp_state_e st;
    logic [31:0] lo;
    logic [31:0] hi;
    logic [3:0] run;
    logic [15:0] tmo;
    logic tmo_dis;
    logic err;
    logic restart;
    logic [ADDR_W-1:0] fetch_addr;
    logic [15:0] beats;
    logic [18:0] ns;
    logic req_valid;
    logic [3:0] req_log;
    logic [3:0] max_log;
    logic [31:0] rdata;
  } sgp_mgr_s;

  sgp_mgr_s s_r, s_nxt;
  logic [CACHE_LOG:0] free;
  logic cache_wr;
  logic cache_flush;
  logic [3:0] cur_log;
  logic [4:0] max_sum;
  logic [18:0] tmo_limit;
  logic timed_out;
  logic [15:0] group_cnt;

  // The largest group is what one maximum-size read request can carry.
  assign max_sum = 5'(max_read_req) + 5'(MRRS_BASE_LOG) - 5'(DESC_BYTES_LOG);
  // A group must also fit in the cache, or it could never be reserved.
  assign cur_log = (s_r.max_log < CACHE_LOG_V) ? s_r.max_log : CACHE_LOG_V;
  assign group_cnt = 16'h0001 << cur_log;
  // Time spent waiting is kept in ns so the 4 ns unit needs no divider.
  assign tmo_limit = 19'(s_r.tmo) * 19'(TMO_UNIT_NS);
  assign timed_out = !s_r.tmo_dis && (s_r.ns >= tmo_limit);

  // Register file, fetch sequencer and abort handling.
  always_comb begin
    s_nxt = s_r;
    cache_wr = 1'b0;
    cache_flush = 1'b0;
    s_nxt.max_log = (max_sum > 5'(GROUP_LOG_MAX)) ? GROUP_LOG_MAX : max_sum[3:0];
    if (reg_wr) begin
      unique case (reg_addr)
        REG_ADDR_LO: s_nxt.lo = reg_wdata;
        REG_ADDR_HI: s_nxt.hi = reg_wdata;
        REG_CTRL: begin
          s_nxt.run = reg_wdata[RUN_LSB +: 4];
          if (reg_wdata[ERR_BIT]) begin
            s_nxt.err = 1'b0;
          end
        end
        REG_TMO: begin
          if (s_r.st == ST_IDLE) begin
            s_nxt.tmo = reg_wdata[TMO_LSB +: 16];
            s_nxt.tmo_dis = reg_wdata[TMO_DIS_BIT];
          end
        end
      endcase
    end
    if (reg_rd) begin
      unique case (reg_addr)
        REG_ADDR_LO: s_nxt.rdata = s_r.lo;
        REG_ADDR_HI: s_nxt.rdata = s_r.hi;
        REG_CTRL: begin
          s_nxt.rdata = '0;
          s_nxt.rdata[RUN_LSB +: 4] = s_r.run;
          s_nxt.rdata[STATE_LSB +: 2] = s_r.st;
          s_nxt.rdata[ERR_BIT] = s_r.err;
          s_nxt.rdata[CUR_LSB +: 4] = cur_log;
          s_nxt.rdata[MAX_LSB +: 4] = s_r.max_log;
        end
        REG_TMO: begin
          s_nxt.rdata = '0;
          s_nxt.rdata[TMO_LSB +: 16] = s_r.tmo;
          s_nxt.rdata[TMO_DIS_BIT] = s_r.tmo_dis;
        end
      endcase
    end
    // Abort empties the cache every cycle it is held except a cycle in which a drain times out, so nothing stale survives.
    if (s_r.run == RUN_ABORT) begin
      cache_flush = 1'b1;
      s_nxt.restart = 1'b1;
    end
    unique case (s_r.st)
      ST_IDLE: begin
        // Fetching ignores the engine; only the run level, the error flag and cache room gate it.
        if (s_r.run == RUN_GO && !s_r.err && free >= (CACHE_LOG+1)'(group_cnt)) begin
          s_nxt.req_valid = 1'b1;
          s_nxt.req_log = cur_log;
          s_nxt.st = ST_REQ;
          if (s_r.restart) begin
            s_nxt.fetch_addr = {s_r.hi, s_r.lo};
            s_nxt.restart = 1'b0;
          end
        end
      end
      ST_REQ: begin
        if (link.rd_req_ready) begin
          s_nxt.req_valid = 1'b0;
          s_nxt.beats = 16'h0001 << s_r.req_log;
          s_nxt.ns = '0;
          s_nxt.st = (s_r.run == RUN_ABORT) ? ST_DRAIN : ST_WAIT;
        end else if (s_r.run == RUN_ABORT) begin
          s_nxt.req_valid = 1'b0;
          s_nxt.st = ST_IDLE;
        end
      end
      ST_WAIT, ST_DRAIN: begin
        if (link.cpl_valid) begin
          // Beats in drain belong to an aborted group and are thrown away.
          cache_wr = (s_r.st == ST_WAIT) && (s_r.run != RUN_ABORT);
          s_nxt.ns = '0;
          s_nxt.beats = s_r.beats - 16'h0001;
          if (s_r.beats == 16'h0001) begin
            s_nxt.st = ST_IDLE;
            // The next group starts right after the last descriptor of this one.
            s_nxt.fetch_addr = s_r.fetch_addr
              + ADDR_W'(32'(16'h0001 << s_r.req_log) * 32'(DESC_BYTES));
          end
        end else if (timed_out) begin
          // A lost completion leaves the list position unknown, so restart it.
          s_nxt.err = (s_r.st == ST_WAIT);
          s_nxt.restart = 1'b1;
          s_nxt.st = ST_IDLE;
          cache_flush = (s_r.st == ST_WAIT);
        end else if (s_r.ns < tmo_limit) begin
          s_nxt.ns = s_r.ns + CLK_NS;
        end
        if (s_r.st == ST_WAIT && s_r.run == RUN_ABORT) begin
          s_nxt.st = (s_nxt.st == ST_IDLE) ? ST_IDLE : ST_DRAIN;
        end
      end
    endcase
  end

  // After reset the first run fetches from the programmed start address.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      s_r <= '{st: ST_IDLE, lo: ADDR_RST, hi: ADDR_RST, run: RUN_IDLE, tmo: TMO_RST,
               tmo_dis: TMO_DIS_RST, restart: 1'b1, default: '0};
    end else begin
      s_r <= s_nxt;
    end
  end

  // The cache hands descriptors to the engine in the order they arrived.
  sgp_cache #(
    .DEPTH_LOG(CACHE_LOG)
  ) i_sgp_cache (
    .clock(clock),
    .resetn(resetn),
    .flush(cache_flush),
    .wr_valid(cache_wr),
    .wr_data(link.cpl_data),
    .free(free),
    .rd_valid(link.desc_valid),
    .rd_data(link.desc_data),
    .rd_ready(link.desc_ready)
  );

  // Link and register outputs come straight from the state register.
  assign link.rd_req_valid = s_r.req_valid;
  assign link.rd_req_addr = s_r.fetch_addr;
  assign link.rd_req_log = s_r.req_log;
  assign reg_rdata = s_r.rdata;
endmodule : sgp_mgr

// *** tb/sgp_properties.sv ***
// Concurrent checks on the link between the prefetch manager and its far end.
`timescale 1ns/100ps
module sgp_properties
  import sgp_pkg::*;
#(
  parameter int CACHE_LOG = 4
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic rd_req_valid,
  input wire logic [ADDR_W-1:0] rd_req_addr,
  input wire logic [3:0] rd_req_log,
  input wire logic rd_req_ready,
  input wire logic cpl_valid,
  input wire logic [DESC_W-1:0] cpl_data,
  input wire logic desc_valid,
  input wire logic [DESC_W-1:0] desc_data,
  input wire logic desc_ready
);
  logic [16:0] beats_r;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);
  sequence s_take;
    rd_req_valid && rd_req_ready;
  endsequence
  sequence s_hand;
    desc_valid && desc_ready;
  endsequence
  // Beats still owed for the group in flight; a surplus beat would smuggle in a descriptor.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      beats_r <= 17'h00000;
    end else if (rd_req_valid && rd_req_ready) begin
      beats_r <= 17'h00001 << rd_req_log;
    end else if (cpl_valid && beats_r != 17'h00000) begin
      beats_r <= beats_r - 17'h00001;
    end
  end
  sequence s_pend;
    rd_req_valid && !rd_req_ready;
  endsequence
  // A pending request may only be withdrawn by abort, never altered in place.
  property p_req_hold;
    s_pend |=> !rd_req_valid || $stable({rd_req_addr, rd_req_log});
  endproperty
  // A beat landing in an empty cache is the next descriptor offered.
  property p_first_in;
    !desc_valid && cpl_valid |=> !desc_valid || desc_data == $past(cpl_data);
  endproperty
  AST_FIRST_BEAT: assert property (s_take |-> ##3 cpl_valid)
    else $error("first beat not three cycles after the request was taken");
  AST_SPACING: assert property (s_take |=> !(rd_req_valid && rd_req_ready) [*4])
    else $error("second request taken while a group was outstanding");
  AST_GROUP_CAP: assert property (rd_req_valid |-> rd_req_log <= CACHE_LOG)
    else $error("group size beyond the allowed group");
  AST_BEAT_COUNT: assert property (cpl_valid |-> beats_r != 17'h00000)
    else $error("more beats than the group holds");
  AST_BEAT_RUN: assert property (cpl_valid && beats_r > 17'h00001 |=> cpl_valid)
    else $error("group beats not delivered back to back");
  AST_HANDOFF: assert property (s_hand |=> !desc_ready)
    else $error("engine asked for a second descriptor while holding one");
  AST_DESC_HOLD: assert property (desc_valid && !desc_ready |=> !desc_valid || $stable(desc_data))
    else $error("offered descriptor changed before hand-off");
  AST_RESET_QUIET: assert property ($rose(resetn) |-> !rd_req_valid && !desc_valid)
    else $error("link not idle after reset");
  AST_REQ_HOLD: assert property (p_req_hold)
    else $error("read request changed before it was taken");
  AST_FIRST_IN: assert property (p_first_in)
    else $error("offered descriptor is not the beat that filled the cache");
endmodule : sgp_properties

// *** tb/tb_sg_descriptor_prefetcher.sv ***
// Self-checking bench joining both ends of the descriptor prefetcher.
`timescale 1ns/100ps
module tb_sg_descriptor_prefetcher
  import sgp_pkg::*;
;
  localparam logic [63:0] BASE = 64'h0000_0001_0000_1000;
  localparam logic [63:0] PAT = 64'ha5a5_5a5a_0f0f_f0f0;
  logic clock, resetn, reg_wr, reg_rd, mem_rd_en, cur_valid;
  logic [2:0] max_read_req;
  logic [1:0] reg_addr, eng_state;
  logic [31:0] reg_wdata, reg_rdata;
  logic [63:0] mem_addr, mem_rdata, cur_desc;
  logic [3:0] cmd;
  int fail_count, num_checks, takes, cycles;
  sgp_if link ();
  sgp_mgr #(.CACHE_LOG(2)) i_sgp_mgr (.clock(clock), .resetn(resetn), .link(link.mgr),
    .max_read_req(max_read_req), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
  sgp_far i_sgp_far (.clock(clock), .resetn(resetn), .link(link.far), .mem_rd_en(mem_rd_en),
    .mem_addr(mem_addr), .mem_rdata(mem_rdata), .eng_start(cmd[0]), .eng_stop(cmd[1]),
    .eng_abort(cmd[2]), .chunk_done(cmd[3]), .eng_state(eng_state), .cur_valid(cur_valid),
    .cur_desc(cur_desc));
  sgp_properties #(.CACHE_LOG(2)) i_sgp_properties (.clock(clock), .resetn(resetn),
    .rd_req_valid(link.rd_req_valid), .rd_req_addr(link.rd_req_addr),
    .rd_req_log(link.rd_req_log), .rd_req_ready(link.rd_req_ready),
    .cpl_valid(link.cpl_valid), .cpl_data(link.cpl_data), .desc_valid(link.desc_valid),
    .desc_data(link.desc_data), .desc_ready(link.desc_ready));
  // Host memory answers at the falling edge within the read cycle; idle cycles show the inverse word.
  always @(negedge clock) mem_rdata <= mem_rd_en ? mem_addr ^ PAT : ~(mem_addr ^ PAT);
  // Counts taken requests and cuts a hang short well past the expected run length.
  always @(posedge clock) begin
    cycles++;
    if (link.rd_req_valid && link.rd_req_ready) takes++;
    if (cycles == 20000) begin
      fail_count++;
      stop_test();
    end
  end
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  task automatic stop_test();
    if (fail_count == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : stop_test
  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic wr(input logic [1:0] a, input logic [31:0] d);
    @(negedge clock);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge clock);
    reg_wr = 1'b0;
  endtask : wr
  // Read data lands on the edge after the strobe, so it is picked up at the next fall.
  task automatic rd_chk(input logic [1:0] a, input logic [31:0] exp);
    @(negedge clock);
    reg_rd = 1'b1;
    reg_addr = a;
    @(negedge clock);
    reg_rd = 1'b0;
    check({32'h0, reg_rdata}, {32'h0, exp});
  endtask : rd_chk
  task automatic pulse(input logic [3:0] c);
    @(negedge clock);
    cmd = c;
    @(negedge clock);
    cmd = 4'h0;
  endtask : pulse
  // A silent cache would leave a stale descriptor, so presence is judged too.
  task automatic take_desc(input logic [63:0] addr);
    for (int i = 0; i < 200 && cur_valid !== 1'b1; i++) @(negedge clock);
    check({63'h0, cur_valid}, 64'h1);
    check(cur_desc, addr ^ PAT);
    pulse(4'h8);
  endtask : take_desc
  // Reset values, derived group fields for two read sizes, start address words.
  task automatic t_regs();
    rd_chk(REG_ADDR_LO, ADDR_RST);
    rd_chk(REG_TMO, {16'h0000, TMO_RST});
    rd_chk(REG_CTRL, 32'h4200_0000);
    max_read_req = 3'h7;
    rd_chk(REG_CTRL, 32'hb200_0000);
    wr(REG_ADDR_LO, BASE[31:0]);
    wr(REG_ADDR_HI, BASE[63:32]);
    rd_chk(REG_ADDR_LO, BASE[31:0]);
    rd_chk(REG_ADDR_HI, BASE[63:32]);
  endtask : t_regs
  // Fetching with the engine stopped fills the cache, then pauses until it drains.
  task automatic t_fetch();
    wr(REG_CTRL, {28'h0, RUN_GO});
    repeat (100) @(negedge clock);
    check(64'(takes), 64'h1);
    pulse(4'h1);
    for (int i = 0; i < 4; i++) take_desc(BASE + 64'(8 * i));
    for (int i = 0; i < 50 && takes < 2; i++) @(negedge clock);
    wr(REG_CTRL, {28'h0, RUN_IDLE});
    for (int i = 4; i < 8; i++) take_desc(BASE + 64'(8 * i));
    repeat (50) @(negedge clock);
    check(64'(takes), 64'h2);
  endtask : t_fetch
  // Stop the engine, abort the manager, and see the list restart at its head.
  task automatic t_abort();
    wr(REG_CTRL, {28'h0, RUN_GO});
    take_desc(BASE + 64'h40);
    pulse(4'h2);
    pulse(4'h8);
    repeat (4) @(negedge clock);
    check({62'h0, eng_state}, {62'h0, ENG_STOPPED});
    wr(REG_CTRL, {28'h0, RUN_ABORT});
    rd_chk(REG_CTRL, 32'hb200_0002);
    wr(REG_CTRL, {28'h0, RUN_GO});
    pulse(4'h1);
    take_desc(BASE);
  endtask : t_abort
  // A one-unit timeout is shorter than a clock, so the first wait must fail.
  task automatic t_timeout();
    wr(REG_CTRL, {28'h0, RUN_ABORT});
    pulse(4'h4);
    wr(REG_TMO, 32'h0000_0001);
    rd_chk(REG_TMO, 32'h0000_0001);
    wr(REG_CTRL, {28'h0, RUN_GO});
    // This write lands while the request is pending, so it must be ignored.
    wr(REG_TMO, 32'h0000_0002);
    repeat (20) @(negedge clock);
    rd_chk(REG_CTRL, 32'hb200_0101);
    rd_chk(REG_TMO, 32'h0000_0001);
    wr(REG_CTRL, 32'h0000_0100);
    rd_chk(REG_CTRL, 32'hb200_0000);
    wr(REG_TMO, 32'h8000_0001);
    rd_chk(REG_TMO, 32'h8000_0001);
    wr(REG_CTRL, {28'h0, RUN_GO});
    pulse(4'h1);
    take_desc(BASE);
  endtask : t_timeout
  initial begin
    resetn = 1'b0;
    max_read_req = 3'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 2'h0;
    reg_wdata = 32'h0;
    cmd = 4'h0;
    repeat (2) @(negedge clock);
    resetn = 1'b1;
    t_regs();
    t_fetch();
    t_abort();
    t_timeout();
    stop_test();
  end
endmodule : tb_sg_descriptor_prefetcher
